// >>> hbep_bridge_ctrl.sv
// Top of the half-bridge enable and protection block.
// Assumes the serial slave decodes frames and presents
// one-cycle register strobes on clk_i; analogue inputs
// are asynchronous and synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "hbep_consts.svh"

module hbep_bridge_ctrl (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Register port from the serial slave
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [4:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Analogue comparators, asynchronous
    input wire logic [3:0] high_side_current_trip_i,
    input wire logic [3:0] low_side_current_trip_i,
    input wire logic [3:0] open_short_cmp_i,
    input wire logic thermal_fault_i,
    input wire logic supply_high_fault_i,
    input wire logic supply_low_fault_i,
    input wire logic charge_pump_fault_i,
    // Interrupt flags of the supply monitor, same clock
    input wire logic [3:0] fault_irq_flags_i,
    // Mode control, same clock
    input wire logic low_power_entry_i,
    // PWM, same clock
    input wire logic [3:0] pwm_en_i,
    input wire logic [3:0] pwm_i,
    // Power stage and diagnostics
    output logic [3:0] high_switch_on_o,
    output logic [3:0] low_switch_on_o,
    output logic [7:0] diag_source_ctrl_o,
    // Status-byte summary bit
    output logic bridge_overcurrent_summary_o
);

    //****************************************************
    // Input synchronisers
    //****************************************************
    logic [`HBEP_SYNC_W-1:0] sync_a;
    logic [`HBEP_SYNC_W-1:0] sync_b;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {charge_pump_fault_i,
                       supply_low_fault_i,
                       supply_high_fault_i,
                       thermal_fault_i,
                       open_short_cmp_i,
                       low_side_current_trip_i,
                       high_side_current_trip_i};
            sync_b <= sync_a;
        end
    end

    hbep_pkg::hbep_drv_t och_s;
    hbep_pkg::hbep_drv_t ocl_s;
    hbep_pkg::hbep_drv_t osf_s;
    logic [3:0] fault_s;

    assign och_s = sync_b[3:0];
    assign ocl_s = sync_b[7:4];
    assign osf_s = sync_b[11:8];
    assign fault_s = sync_b[15:12];

    //****************************************************
    // Thermal event edge
    //****************************************************
    logic therm_q;
    logic therm_rise;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            therm_q <= 1'b0;
        end else begin
            therm_q <= fault_s[`HBEP_FLT_THERM];
        end
    end

    assign therm_rise = fault_s[`HBEP_FLT_THERM] & ~therm_q;

    //****************************************************
    // Over-current qualification per driver
    //****************************************************
    hbep_pkg::hbep_drv_t oc_raw;
    hbep_pkg::hbep_drv_t trip;

    assign oc_raw = och_s | ocl_s;

    genvar gi;
    generate
        for (gi = 0; gi < `HBEP_NUM_DRV; gi++) begin : g_drv
            hbep_oc_integrator u_oc (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .oc_i(oc_raw[gi]),
                .trip_o(trip[gi])
            );
        end
    endgenerate

    //****************************************************
    // Register strobes
    //****************************************************
    logic wr_ctrl;
    logic wr_diag;
    logic wr_stat;

    assign wr_ctrl = reg_wr_i && (reg_addr_i == `HBEP_ADDR_CTRL);
    assign wr_diag = reg_wr_i && (reg_addr_i == `HBEP_ADDR_DIAG);
    assign wr_stat = reg_wr_i && (reg_addr_i == `HBEP_ADDR_STAT);

    //****************************************************
    // Enable control register
    //****************************************************
    hbep_pkg::hbep_byte_t enable_ctrl;

    // Automatic clears beat a write in the same cycle,
    // so software cannot re-arm through a mode change.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            enable_ctrl <= `HBEP_RST_BYTE;
        end else if (low_power_entry_i) begin
            enable_ctrl <= `HBEP_RST_BYTE;
        end else if (therm_rise) begin
            enable_ctrl <= `HBEP_RST_BYTE;
        end else if (wr_ctrl) begin
            enable_ctrl <= reg_wdata_i;
        end
    end

    //****************************************************
    // Diagnostic source register
    //****************************************************
    hbep_pkg::hbep_byte_t diag_ctrl;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            diag_ctrl <= `HBEP_RST_BYTE;
        end else if (therm_rise) begin
            diag_ctrl <= `HBEP_RST_BYTE;
        end else if (wr_diag) begin
            diag_ctrl <= reg_wdata_i;
        end
    end

    assign diag_source_ctrl_o = diag_ctrl;

    //****************************************************
    // Over-current flags, write one to clear
    //****************************************************
    hbep_pkg::hbep_drv_t oc_flags;
    hbep_pkg::hbep_drv_t next_oc_flags;
    hbep_pkg::hbep_drv_t oc_clr;

    assign oc_clr = wr_stat ? reg_wdata_i[`HBEP_OCF_MSB:`HBEP_OCF_LSB]
                            : `HBEP_RST_DRV;
    // A trip in the clearing cycle survives the clear
    assign next_oc_flags = (oc_flags & ~oc_clr) | trip;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oc_flags <= `HBEP_RST_DRV;
        end else begin
            oc_flags <= next_oc_flags;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bridge_overcurrent_summary_o <= 1'b0;
        end else begin
            bridge_overcurrent_summary_o <= |next_oc_flags;
        end
    end

    //****************************************************
    // Switch enables and safety gating
    //****************************************************
    hbep_pkg::hbep_drv_t hen;
    hbep_pkg::hbep_drv_t len;
    hbep_pkg::hbep_drv_t legal;
    hbep_pkg::hbep_drv_t pwm_ok;
    hbep_pkg::hbep_drv_t drv_ok;
    logic gate_all;

    assign hen = hbep_pkg::hbep_high(enable_ctrl);
    assign len = hbep_pkg::hbep_low(enable_ctrl);
    assign legal = hen ^ len;
    assign pwm_ok = ~pwm_en_i | pwm_i;
    // Flagged failures gate, supply faults act at once
    assign gate_all = (|(fault_s & fault_irq_flags_i))
                    | fault_s[`HBEP_FLT_HIGH]
                    | fault_s[`HBEP_FLT_LOW];
    assign drv_ok = legal & ~oc_flags & ~{4{gate_all}};

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            high_switch_on_o <= `HBEP_RST_DRV;
            low_switch_on_o <= `HBEP_RST_DRV;
        end else begin
            high_switch_on_o <= drv_ok & hen & pwm_ok;
            low_switch_on_o <= drv_ok & len & pwm_ok;
        end
    end

    //****************************************************
    // Status read-back
    //****************************************************
    hbep_pkg::hbep_drv_t diag_en;
    hbep_pkg::hbep_drv_t osf_live;

    assign diag_en = hbep_pkg::hbep_high(diag_ctrl)
                   | hbep_pkg::hbep_low(diag_ctrl);
    // Unlatched: no diagnostic source means no result
    assign osf_live = osf_s & diag_en;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= `HBEP_RST_BYTE;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `HBEP_ADDR_CTRL: begin
                    reg_rdata_o <= enable_ctrl;
                end
                `HBEP_ADDR_DIAG: begin
                    reg_rdata_o <= diag_ctrl;
                end
                `HBEP_ADDR_STAT: begin
                    reg_rdata_o <= {osf_live, oc_flags};
                end
                default: begin
                    reg_rdata_o <= `HBEP_RST_BYTE;
                end
            endcase
        end
    end

    //****************************************************
    // Checks
    //****************************************************
    sequence s_stat_read;
        reg_rd_i && (reg_addr_i == `HBEP_ADDR_STAT);
    endsequence

    sequence s_stat_clear;
        wr_stat && (trip == `HBEP_RST_DRV);
    endsequence

    a_pair_safety: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ((high_switch_on_o | low_switch_on_o) & ~$past(legal))
            == `HBEP_RST_DRV)
        else $error("switch on with equal enable pair");

    a_lowpower_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        low_power_entry_i |=> enable_ctrl == `HBEP_RST_BYTE
            ##1 (high_switch_on_o | low_switch_on_o) == `HBEP_RST_DRV)
        else $error("enables survive low-power entry");

    a_thermal_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        therm_rise |=> enable_ctrl == `HBEP_RST_BYTE
            && diag_ctrl == `HBEP_RST_BYTE)
        else $error("enables survive thermal event");

    a_fault_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (|(fault_s & fault_irq_flags_i)) |=>
            (high_switch_on_o | low_switch_on_o) == `HBEP_RST_DRV)
        else $error("flagged failure did not gate outputs");

    a_supply_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (fault_s[`HBEP_FLT_HIGH] || fault_s[`HBEP_FLT_LOW]) |=>
            (high_switch_on_o | low_switch_on_o) == `HBEP_RST_DRV)
        else $error("drivers on during supply fault");

    a_flag_blocks: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ((high_switch_on_o | low_switch_on_o) & $past(oc_flags))
            == `HBEP_RST_DRV)
        else $error("driver on while over-current flag set");

    a_trip_sets: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (trip != `HBEP_RST_DRV) |=> (oc_flags & $past(trip)) == $past(trip))
        else $error("qualified trip did not set flag");

    a_w1c_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_stat_clear |=> (oc_flags & $past(reg_wdata_i[3:0]))
            == `HBEP_RST_DRV)
        else $error("write one did not clear flag");

    a_osf_live: assert property (@(posedge clk_i) disable iff (!rstn_i)
        s_stat_read |=> reg_rdata_o[`HBEP_OSF_MSB:`HBEP_OSF_LSB]
            == ($past(osf_s) & $past(diag_en)))
        else $error("open/short read-back wrong");

    a_summary_or: assert property (@(posedge clk_i) disable iff (!rstn_i)
        bridge_overcurrent_summary_o == (|oc_flags))
        else $error("summary bit differs from flag OR");

endmodule
`default_nettype wire

// >>> hbep_consts.svh
// Named constants for the half-bridge enable and protection block.
// Assumes a 40 MHz system clock and a byte-wide register port.
//
// Functional notes
// - Four identical half-bridge drivers, one to four.
// - Control 0x06: high odd bits, low even.
// - Equal enable pair keeps both switches off.
// - Each driver has its own PWM enable.
// - Low-power mode entry clears all enables.
// - Over-temperature event clears all enables.
// - Flagged failures gate enables, outputs stay off.
// - Either switch over-current disables that driver.
// - Supply over/under-voltage disables all drivers.
// - Status 0x0A: open/short read-only, over-current W1C.
// - Open/short flags mirror live comparator result.
// - Open/short meaning depends on diag sources.
// - Over-current flag keeps its driver disabled.
// - Over-current qualifies only after 20 us.
// - Qualifier counts up on fault, down otherwise.
`ifndef HBEP_CONSTS_SVH
`define HBEP_CONSTS_SVH

//****************************************************
// Register map
//****************************************************
`define HBEP_ADDR_CTRL 5'h06
`define HBEP_ADDR_DIAG 5'h07
`define HBEP_ADDR_STAT 5'h0A
`define HBEP_RST_BYTE 8'h00
`define HBEP_RST_DRV 4'h0
`define HBEP_OSF_MSB 7
`define HBEP_OSF_LSB 4
`define HBEP_OCF_MSB 3
`define HBEP_OCF_LSB 0

//****************************************************
// Driver count and fault vector layout
//****************************************************
`define HBEP_NUM_DRV 4
`define HBEP_FLT_THERM 0
`define HBEP_FLT_HIGH 1
`define HBEP_FLT_LOW 2
`define HBEP_FLT_CP 3
`define HBEP_SYNC_W 16

//****************************************************
// Timing
//****************************************************
`define HBEP_CLK_PERIOD_NS 25
`define HBEP_OC_TIME_NS 20000
`define HBEP_OC_CYCLES ((`HBEP_OC_TIME_NS + `HBEP_CLK_PERIOD_NS - 1) / `HBEP_CLK_PERIOD_NS)
`define HBEP_OC_CW 10
`define HBEP_OC_ZERO 10'h000
`define HBEP_OC_ONE 10'h001

`endif

// >>> hbep_host_model.sv
// Controller side of the register port: issues strobes.
// Assumes the bench calls wr/rd hierarchically, one at a time.
`timescale 1ns/1ps
`default_nettype none

module hbep_host_model (
    // Clock
    input wire logic clk_i,
    // Register port towards the block
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [4:0] reg_addr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 5'h00;
        reg_wdata_o = 8'h00;
    end

    //****************************************************
    // Register cycles
    //****************************************************
    // Writing one to an over-current flag re-enables a driver
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_o <= 1'b1;
        reg_addr_o <= a;
        reg_wdata_o <= d;
        @(posedge clk_i);
        reg_wr_o <= 1'b0;
    endtask

    // Extra edge before sampling: read data is registered
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_i);
        reg_rd_o <= 1'b1;
        reg_addr_o <= a;
        @(posedge clk_i);
        reg_rd_o <= 1'b0;
        @(posedge clk_i);
        #1;
        d = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> hbep_oc_integrator.sv
// Over-current qualifier for one driver.
// Assumes oc_i is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "hbep_consts.svh"

module hbep_oc_integrator (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Live over-current of either switch
    input wire logic oc_i,
    // One-cycle qualified trip
    output logic trip_o
);

    localparam logic [`HBEP_OC_CW-1:0] LIMIT_M1 =
        `HBEP_OC_CW'(`HBEP_OC_CYCLES - 1);

    logic [`HBEP_OC_CW-1:0] cnt;

    //****************************************************
    // Integrator
    //****************************************************
    // Restart from zero on a trip, so a persisting fault
    // needs a full window again, counted from that trip.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt <= `HBEP_OC_ZERO;
        end else if (oc_i) begin
            if (cnt == LIMIT_M1) begin
                cnt <= `HBEP_OC_ZERO;
            end else begin
                cnt <= cnt + `HBEP_OC_ONE;
            end
        end else if (cnt != `HBEP_OC_ZERO) begin
            cnt <= cnt - `HBEP_OC_ONE;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trip_o <= 1'b0;
        end else begin
            trip_o <= oc_i && (cnt == LIMIT_M1);
        end
    end

    a_count_down: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!oc_i && cnt != `HBEP_OC_ZERO) |=> cnt == $past(cnt) - `HBEP_OC_ONE)
        else $error("integrator did not count down");

    a_trip_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
        trip_o |-> $past(oc_i) && $past(cnt) == LIMIT_M1)
        else $error("trip without full qualification");

endmodule
`default_nettype wire

// >>> hbep_pkg.sv
// Types and byte-layout helpers for the half-bridge block.
// Assumes hbep_consts.svh is available on the include path.
package hbep_pkg;

    typedef logic [3:0] hbep_drv_t;
    typedef logic [7:0] hbep_byte_t;

    // High-side enables sit on the odd bits
    function automatic hbep_drv_t hbep_high(input hbep_byte_t b);
        hbep_high = {b[7], b[5], b[3], b[1]};
    endfunction

    // Low-side enables sit on the even bits
    function automatic hbep_drv_t hbep_low(input hbep_byte_t b);
        hbep_low = {b[6], b[4], b[2], b[0]};
    endfunction

endpackage

// >>> tb_top.sv
// Self-checking bench for the half-bridge enable and protection block.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [3:0] pen;
        logic [3:0] pwm;
        logic [3:0] hi;
        logic [3:0] lo;
    } hbep_row_t;

    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic reg_wr, reg_rd;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, diag_o, rd_v;
    logic [3:0] hs_trip = 4'h0, ls_trip = 4'h0, osc = 4'h0;
    logic therm = 1'b0, sup_hi = 1'b0, sup_lo = 1'b0, cp = 1'b0;
    logic [3:0] irqf = 4'h0, pen = 4'h0, pwm = 4'h0, hi_o, lo_o;
    logic lp = 1'b0, summ_o;
    int num_errors = 0;
    int n_tests = 0;
    int k;
    hbep_row_t rows [8] = '{
        '{8'h01, 4'h0, 4'h0, 4'h0, 4'h1}, '{8'h02, 4'h0, 4'h0, 4'h1, 4'h0},
        '{8'h03, 4'h0, 4'h0, 4'h0, 4'h0}, '{8'h99, 4'h0, 4'h0, 4'hA, 4'h5},
        '{8'hAA, 4'h0, 4'h0, 4'hF, 4'h0}, '{8'h55, 4'h0, 4'h0, 4'h0, 4'hF},
        '{8'h00, 4'h0, 4'h0, 4'h0, 4'h0}, '{8'h55, 4'h3, 4'h1, 4'h0, 4'hD}};

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    hbep_host_model i_hbep_host_model (.clk_i(clk_i), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata));

    hbep_bridge_ctrl i_hbep_bridge_ctrl (.clk_i(clk_i), .rstn_i(rstn_i),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .high_side_current_trip_i(hs_trip), .low_side_current_trip_i(ls_trip),
        .open_short_cmp_i(osc), .thermal_fault_i(therm),
        .supply_high_fault_i(sup_hi), .supply_low_fault_i(sup_lo),
        .charge_pump_fault_i(cp), .fault_irq_flags_i(irqf),
        .low_power_entry_i(lp), .pwm_en_i(pen), .pwm_i(pwm),
        .high_switch_on_o(hi_o), .low_switch_on_o(lo_o),
        .diag_source_ctrl_o(diag_o), .bridge_overcurrent_summary_o(summ_o));

    //****************************************************
    // Helpers
    //****************************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
        i_hbep_host_model.rd(a, rd_v);
        chk("reg_rdata_o", e, rd_v);
    endtask

    task automatic chk_out(input logic [3:0] h, input logic [3:0] l);
        chk("high_switch_on_o", {4'h0, h}, {4'h0, hi_o});
        chk("low_switch_on_o", {4'h0, l}, {4'h0, lo_o});
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    //****************************************************
    // Main sequence
    //****************************************************
    initial begin
        cyc(5);
        rstn_i <= 1'b1;
        cyc(1);
        chk_out(4'h0, 4'h0);
        chk_rd(5'h06, 8'h00);
        chk_rd(5'h0A, 8'h00);
        chk_rd(5'h1F, 8'h00);
        for (k = 0; k < 8; k++) begin
            pen <= rows[k].pen;
            pwm <= rows[k].pwm;
            i_hbep_host_model.wr(5'h06, rows[k].ctrl);
            chk_rd(5'h06, rows[k].ctrl);
            chk_out(rows[k].hi, rows[k].lo);
        end
        pen <= 4'h0;
        // Sleep entry pulse clears every enable
        lp <= 1'b1;
        cyc(1);
        lp <= 1'b0;
        chk_rd(5'h06, 8'h00);
        chk_out(4'h0, 4'h0);
        i_hbep_host_model.wr(5'h06, 8'h55);
        therm <= 1'b1;
        cyc(6);
        chk_rd(5'h06, 8'h00);
        therm <= 1'b0;
        // Flagged fault gates outputs but keeps the register
        i_hbep_host_model.wr(5'h06, 8'h55);
        cp <= 1'b1;
        irqf <= 4'h8;
        cyc(6);
        chk_out(4'h0, 4'h0);
        chk_rd(5'h06, 8'h55);
        cp <= 1'b0;
        irqf <= 4'h0;
        cyc(6);
        chk_out(4'h0, 4'hF);
        for (k = 0; k < 2; k++) begin
            sup_hi <= (k == 0);
            sup_lo <= (k == 1);
            cyc(6);
            chk_out(4'h0, 4'h0);
            sup_hi <= 1'b0;
            sup_lo <= 1'b0;
            cyc(6);
            chk_out(4'h0, 4'hF);
        end
        // Short burst then pause: counter must wind back down
        ls_trip <= 4'h1;
        cyc(400);
        ls_trip <= 4'h0;
        cyc(400);
        ls_trip <= 4'h1;
        cyc(795);
        chk_out(4'h0, 4'hF);
        chk("summary", 8'h00, {7'h00, summ_o});
        k = 0;
        while (summ_o !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        if (k >= 20) begin
            num_errors++;
            tally_and_finish();
        end
        // Flag lands 803 edges after the pin returns high
        chk("trip_wait", 8'h08, k[7:0]);
        cyc(2);
        chk_out(4'h0, 4'hE);
        chk_rd(5'h0A, 8'h01);
        i_hbep_host_model.wr(5'h0A, 8'h00);
        chk_rd(5'h0A, 8'h01);
        ls_trip <= 4'h0;
        cyc(4);
        chk_out(4'h0, 4'hE);
        i_hbep_host_model.wr(5'h0A, 8'hF1);
        chk_rd(5'h0A, 8'h00);
        chk("summary", 8'h00, {7'h00, summ_o});
        chk_out(4'h0, 4'hF);
        // High switch trip on driver 4, no down-count in between
        i_hbep_host_model.wr(5'h06, 8'hAA);
        hs_trip <= 4'h8;
        cyc(815);
        chk_out(4'h7, 4'h0);
        chk("summary", 8'h01, {7'h00, summ_o});
        hs_trip <= 4'h0;
        i_hbep_host_model.wr(5'h0A, 8'h08);
        chk_rd(5'h0A, 8'h00);
        // Open/short flag is live and needs a diag source
        osc <= 4'hF;
        cyc(4);
        chk_rd(5'h0A, 8'h00);
        i_hbep_host_model.wr(5'h07, 8'h03);
        chk_rd(5'h0A, 8'h10);
        chk("diag_source_ctrl_o", 8'h03, diag_o);
        osc <= 4'h0;
        cyc(4);
        chk_rd(5'h0A, 8'h00);
        tally_and_finish();
    end
endmodule
`default_nettype wire
